// >>> common/uhpsr_pkg.sv
// Shared constants for the hub port line swap and port number remap block
package uhpsr_pkg;
  localparam int unsigned NUM_PORTS       = 8;   // Upstream port 0 plus downstream 1..7
  localparam int unsigned NUM_DOWNSTREAM  = 7;
  localparam logic [7:0] ADDR_LINE_SWAP   = 8'hFA;
  localparam logic [7:0] ADDR_REMAP_PAIR  = 8'hFB;
  localparam logic [7:0] RST_LINE_SWAP    = 8'h00;
  localparam logic [7:0] RST_REMAP_PAIR   = 8'h21;
  localparam logic [7:0] READ_UNMAPPED    = 8'h00;
  localparam int unsigned UPSTREAM_BIT    = 0;
  localparam int unsigned FIELD_PORT1_LSB = 0;   // Physical port 1 field, bits 3:0
  localparam int unsigned FIELD_PORT2_LSB = 4;   // Physical port 2 field, bits 7:4
  localparam int unsigned FIELD_W         = 4;
  localparam logic [3:0] LOGICAL_DISABLED = 4'h0;
  localparam logic [3:0] LOGICAL_MAX      = 4'h7;
  localparam logic [3:0] IDENT_PORT1      = 4'h1;
  localparam logic [3:0] IDENT_PORT2      = 4'h2;
  localparam logic [3:0] DOWNSTREAM_COUNT = 4'h7;
endpackage

// >>> dv/tb.sv
// Self-checking bench for the hub line swap and port number remap block
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import uhpsr_pkg::*;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] c_p = 8'h3C;
  logic [7:0] c_m = 8'hC3;
  logic [7:0] drv = 8'h00;
  logic [7:0] f_p = 8'h96;
  logic [7:0] f_m = 8'h69;
  logic [7:0] ci_p, ci_m, po, poe, pi, mo, moe, mi, rdata, s;
  logic [3:0] ph1, ph2, cnt, hi, lo;
  logic [7:0] sw [4] = '{8'h01, 8'hFE, 8'h5A, 8'h00};
  int         mismatches = 0;
  int         n_compared = 0;
  // 125 MHz clock
  always #4 clk = ~clk;
  uhpsr_top dut (.REF_CLK(clk), .RESETN(rstn), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .REMAP_MODE_ENABLE(en),
    .CORE_PLUS_OUT(c_p), .CORE_MINUS_OUT(c_m), .CORE_DRIVE(drv),
    .CORE_PLUS_IN(ci_p), .CORE_MINUS_IN(ci_m), .PLUS_LINE_PIN_O(po),
    .PLUS_LINE_PIN_OE(poe), .PLUS_LINE_PIN_I(pi), .MINUS_LINE_PIN_O(mo),
    .MINUS_LINE_PIN_OE(moe), .MINUS_LINE_PIN_I(mi), .PHYS1_LOGICAL(ph1),
    .PHYS2_LOGICAL(ph2), .PORT_COUNT(cnt));
  uhpsr_line_model far (.plus_o(po), .plus_oe(poe), .minus_o(mo), .minus_oe(moe),
    .far_plus(f_p), .far_minus(f_m), .plus_i(pi), .minus_i(mi));
  // Compare, count and report at once
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Pass n edges and settle just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    check(rdata, exp);
  endtask
  // Nibbles above seven are reserved and read as a disabled port
  function automatic logic [3:0] mapf(input logic [3:0] v);
    return (v <= 4'h7) ? v : 4'h0;
  endfunction
  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence: reset values, swap both directions, every remap nibble
  initial
  begin
    step(5);
    rstn = 1'b1;
    check({ph2, ph1}, 8'h21);
    check({4'h0, cnt}, 8'h07);
    rd_reg(ADDR_LINE_SWAP, 8'h00);
    step(1);
    rd_reg(ADDR_REMAP_PAIR, 8'h21);
    step(1);
    rd_reg(8'h10, 8'h00);
    foreach (sw[i])
    begin
      s = sw[i];
      wr_reg(ADDR_LINE_SWAP, s);
      drv = 8'hFF;
      step(2);
      check(po, (c_p & ~s) | (c_m & s));
      check(mo, (c_m & ~s) | (c_p & s));
      check(poe & moe, 8'hFF);
      drv = 8'h00;
      step(2);
      check(ci_p, (f_p & ~s) | (f_m & s));
      check(ci_m, (f_m & ~s) | (f_p & s));
      wr_reg(8'hFC, 8'hFF);
      rd_reg(ADDR_LINE_SWAP, s);
    end
    en = 1'b1;
    for (int n = 0; n < 16; n++)
    begin
      hi = 4'(n);
      lo = ~hi;
      wr_reg(ADDR_REMAP_PAIR, {hi, lo});
      step(1);
      check({ph2, ph1}, {mapf(hi), mapf(lo)});
      check({4'h0, cnt}, 8'(5 + (mapf(hi) != 0) + (mapf(lo) != 0)));
    end
    wr_reg(ADDR_REMAP_PAIR, 8'h12);
    step(1);
    check({ph2, ph1, cnt}, 12'h127);
    wr_reg(ADDR_REMAP_PAIR, 8'h00);
    step(1);
    check({ph2, ph1, cnt}, 12'h005);
    en = 1'b0;
    step(2);
    check({ph2, ph1, cnt}, 12'h217);
    rd_reg(ADDR_REMAP_PAIR, 8'h00);
    tally_and_finish();
  end
endmodule // tb

// >>> dv/uhpsr_line_model.sv
// Far-side line model: the attached device drives the pair when the hub lets go
module uhpsr_line_model
(
  input  wire logic [7:0] plus_o,
  input  wire logic [7:0] plus_oe,
  input  wire logic [7:0] minus_o,
  input  wire logic [7:0] minus_oe,
  input  wire logic [7:0] far_plus,
  input  wire logic [7:0] far_minus,
  output logic      [7:0] plus_i,
  output logic      [7:0] minus_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // Per wire: hub level while it drives, else the device level, never left floating
  assign plus_i  = (plus_o & plus_oe) | (far_plus & ~plus_oe);
  assign minus_i = (minus_o & minus_oe) | (far_minus & ~minus_oe);
endmodule // uhpsr_line_model

// >>> hw/uhpsr_top.sv
// Hub line swap per port and physical-to-logical remap of downstream ports 1 and 2
// What this block, the host and the software do
// [RQ1] Swap bit 0: plus to plus, minus to minus
// [RQ2] Swap bit 1: plus and minus pins exchanged
// [RQ3] Swap bit 0 steers only the upstream port
// [RQ4] Swap bits 1..7 steer downstream ports 1..7
// [RQ5] Report only the downstream port count
// [RQ6] Host numbers ports 1 up to count
// [RQ7] Remap mode translates physical to logical numbers
// [RQ8] Software programs logical numbers contiguously from one
// [RQ9] Upper nibble zero disables physical port 2
// [RQ10] Upper nibble 1..7 maps port 2 there
// [RQ11] Nibbles 8..15 act as zero, disabled
// [RQ12] Lower nibble maps physical port 1, zero disables
// [RQ13] Remap mode off keeps identity numbering
module uhpsr_top
  import uhpsr_pkg::*;
(
  input  wire logic                            REF_CLK,
  input  wire logic                            RESETN,
  input  wire logic [7:0]                      REG_ADDR,
  input  wire logic                            REG_WR,
  input  wire logic [7:0]                      REG_WDATA,
  input  wire logic                            REG_RD,
  output logic      [7:0]                      REG_RDATA,
  input  wire logic                            REMAP_MODE_ENABLE,
  input  wire logic [uhpsr_pkg::NUM_PORTS-1:0] CORE_PLUS_OUT,
  input  wire logic [uhpsr_pkg::NUM_PORTS-1:0] CORE_MINUS_OUT,
  input  wire logic [uhpsr_pkg::NUM_PORTS-1:0] CORE_DRIVE,
  output logic      [uhpsr_pkg::NUM_PORTS-1:0] CORE_PLUS_IN,
  output logic      [uhpsr_pkg::NUM_PORTS-1:0] CORE_MINUS_IN,
  output logic      [uhpsr_pkg::NUM_PORTS-1:0] PLUS_LINE_PIN_O,
  output logic      [uhpsr_pkg::NUM_PORTS-1:0] PLUS_LINE_PIN_OE,
  input  wire logic [uhpsr_pkg::NUM_PORTS-1:0] PLUS_LINE_PIN_I,
  output logic      [uhpsr_pkg::NUM_PORTS-1:0] MINUS_LINE_PIN_O,
  output logic      [uhpsr_pkg::NUM_PORTS-1:0] MINUS_LINE_PIN_OE,
  input  wire logic [uhpsr_pkg::NUM_PORTS-1:0] MINUS_LINE_PIN_I,
  output logic      [3:0]                      PHYS1_LOGICAL,
  output logic      [3:0]                      PHYS2_LOGICAL,
  output logic      [3:0]                      PORT_COUNT
);
  import uhpsr_pkg::*;

  logic [7:0] line_swap_mask;
  logic [7:0] remap_first_pair_field;
  logic [3:0] next_phys1;
  logic [3:0] next_phys2;
  logic [3:0] next_count;

  // Reserved codes fold to disabled so a stray value never yields a bogus port
  function automatic logic [3:0] uhpsr_decode(input logic [3:0] nib);
    uhpsr_decode = (nib > LOGICAL_MAX) ? LOGICAL_DISABLED : nib; // RQ11
  endfunction

  // Register writes at the printed offsets; other addresses are ignored
  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      line_swap_mask         <= RST_LINE_SWAP;
      remap_first_pair_field <= RST_REMAP_PAIR;
    end
    else if (REG_WR)
    begin
      if (REG_ADDR == ADDR_LINE_SWAP)
        line_swap_mask <= REG_WDATA;
      else if (REG_ADDR == ADDR_REMAP_PAIR)
        remap_first_pair_field <= REG_WDATA;
    end
  end

  // Read data registered, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
      REG_RDATA <= READ_UNMAPPED;
    else if (REG_RD)
    begin
      if (REG_ADDR == ADDR_LINE_SWAP)
        REG_RDATA <= line_swap_mask;
      else if (REG_ADDR == ADDR_REMAP_PAIR)
        REG_RDATA <= remap_first_pair_field;
      else
        REG_RDATA <= READ_UNMAPPED;
    end
  end

  // Per-port pin steering; bit 0 is upstream, bits 1..7 downstream
  // Registered for clean pin timing at the cost of one cycle of latency
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++)
    begin : g_port
      always_ff @(posedge REF_CLK)
      begin
        if (!RESETN)
        begin
          PLUS_LINE_PIN_O[gi]   <= 1'b0;
          MINUS_LINE_PIN_O[gi]  <= 1'b0;
          PLUS_LINE_PIN_OE[gi]  <= 1'b0;
          MINUS_LINE_PIN_OE[gi] <= 1'b0;
          CORE_PLUS_IN[gi]      <= 1'b0;
          CORE_MINUS_IN[gi]     <= 1'b0;
        end
        else if (line_swap_mask[gi]) // RQ3 RQ4
        begin
          PLUS_LINE_PIN_O[gi]   <= CORE_MINUS_OUT[gi]; // RQ2
          MINUS_LINE_PIN_O[gi]  <= CORE_PLUS_OUT[gi];
          PLUS_LINE_PIN_OE[gi]  <= CORE_DRIVE[gi];
          MINUS_LINE_PIN_OE[gi] <= CORE_DRIVE[gi];
          CORE_PLUS_IN[gi]      <= MINUS_LINE_PIN_I[gi];
          CORE_MINUS_IN[gi]     <= PLUS_LINE_PIN_I[gi];
        end
        else
        begin
          PLUS_LINE_PIN_O[gi]   <= CORE_PLUS_OUT[gi]; // RQ1
          MINUS_LINE_PIN_O[gi]  <= CORE_MINUS_OUT[gi];
          PLUS_LINE_PIN_OE[gi]  <= CORE_DRIVE[gi];
          MINUS_LINE_PIN_OE[gi] <= CORE_DRIVE[gi];
          CORE_PLUS_IN[gi]      <= PLUS_LINE_PIN_I[gi];
          CORE_MINUS_IN[gi]     <= MINUS_LINE_PIN_I[gi];
        end
      end

      AST_SWAP_OFF: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RQ1
        !line_swap_mask[gi] |=> PLUS_LINE_PIN_O[gi] == $past(CORE_PLUS_OUT[gi])
          && MINUS_LINE_PIN_O[gi] == $past(CORE_MINUS_OUT[gi])
          && CORE_PLUS_IN[gi] == $past(PLUS_LINE_PIN_I[gi])
          && CORE_MINUS_IN[gi] == $past(MINUS_LINE_PIN_I[gi]))
        else $error("unswapped port not straight through");
      AST_SWAP_ON: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RQ2
        line_swap_mask[gi] |=> PLUS_LINE_PIN_O[gi] == $past(CORE_MINUS_OUT[gi])
          && MINUS_LINE_PIN_O[gi] == $past(CORE_PLUS_OUT[gi])
          && CORE_PLUS_IN[gi] == $past(MINUS_LINE_PIN_I[gi])
          && CORE_MINUS_IN[gi] == $past(PLUS_LINE_PIN_I[gi]))
        else $error("swapped port not exchanged");
      // Both enables follow the core drive whatever the swap, so a swap never
      // leaves one wire of the pair undriven
      AST_PIN_ENABLE: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RQ1 RQ2
        1'b1 |=> PLUS_LINE_PIN_OE[gi] == $past(CORE_DRIVE[gi])
          && MINUS_LINE_PIN_OE[gi] == $past(CORE_DRIVE[gi]))
        else $error("pin enables do not follow core drive");
    end
  endgenerate

  // Write of upstream swap bit reaches the upstream pins two edges later
  sequence s_up_swap_write;
    REG_WR && REG_ADDR == ADDR_LINE_SWAP && REG_WDATA[UPSTREAM_BIT];
  endsequence
  sequence s_up_swapped;
    ##2 PLUS_LINE_PIN_O[UPSTREAM_BIT] == $past(CORE_MINUS_OUT[UPSTREAM_BIT]);
  endsequence
  AST_UP_SWAP_WRITE: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RQ3
    s_up_swap_write |-> s_up_swapped)
    else $error("upstream swap write not applied");
  AST_DOWN_SWAP_WRITE: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RQ4
    REG_WR && REG_ADDR == ADDR_LINE_SWAP && !REG_WDATA[7]
      |-> ##2 PLUS_LINE_PIN_O[7] == $past(CORE_PLUS_OUT[7]))
    else $error("port 7 swap write not applied");

  // Logical numbers: remap fields when enabled, identity otherwise
  always_comb
  begin
    if (REMAP_MODE_ENABLE) // RQ7
    begin
      next_phys1 = uhpsr_decode(remap_first_pair_field[FIELD_PORT1_LSB +: FIELD_W]); // RQ12
      next_phys2 = uhpsr_decode(remap_first_pair_field[FIELD_PORT2_LSB +: FIELD_W]); // RQ9 RQ10
    end
    else
    begin
      next_phys1 = IDENT_PORT1; // RQ13
      next_phys2 = IDENT_PORT2;
    end
  end

  // Only a count goes to the host; numbering is left to it, so the
  // count just drops by each disabled physical port
  always_comb
  begin
    next_count = DOWNSTREAM_COUNT; // RQ5
    if (next_phys1 == LOGICAL_DISABLED)
      next_count = next_count - 4'h1;
    if (next_phys2 == LOGICAL_DISABLED)
      next_count = next_count - 4'h1;
  end

  // Remap results registered
  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      PHYS1_LOGICAL <= IDENT_PORT1;
      PHYS2_LOGICAL <= IDENT_PORT2;
      PORT_COUNT    <= DOWNSTREAM_COUNT;
    end
    else
    begin
      PHYS1_LOGICAL <= next_phys1;
      PHYS2_LOGICAL <= next_phys2;
      PORT_COUNT    <= next_count;
    end
  end

  AST_PORT2_DISABLED: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RQ9
    REMAP_MODE_ENABLE && remap_first_pair_field[7:4] == 4'h0 |=> PHYS2_LOGICAL == 4'h0)
    else $error("port 2 not disabled by zero code");
  AST_PORT2_MAPPED: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RQ10 RQ7
    REMAP_MODE_ENABLE && remap_first_pair_field[7:4] inside {[4'h1:4'h7]}
      |=> PHYS2_LOGICAL == $past(remap_first_pair_field[7:4]))
    else $error("port 2 logical number wrong");
  AST_RESERVED: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RQ11
    REMAP_MODE_ENABLE && remap_first_pair_field[7] |=> PHYS2_LOGICAL == 4'h0)
    else $error("reserved code not treated as disabled");
  AST_PORT1_FIELD: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RQ12
    REMAP_MODE_ENABLE && !remap_first_pair_field[3]
      |=> PHYS1_LOGICAL == $past(remap_first_pair_field[3:0]))
    else $error("port 1 logical number wrong");
  AST_IDENTITY: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RQ13
    !REMAP_MODE_ENABLE [*2] |-> PHYS1_LOGICAL == 4'h1 && PHYS2_LOGICAL == 4'h2
      && PORT_COUNT == 4'h7)
    else $error("identity mapping lost with remap off");
  AST_COUNT: assert property (@(posedge REF_CLK) disable iff (!RESETN) // RQ5
    REMAP_MODE_ENABLE && remap_first_pair_field == 8'h00 |=> PORT_COUNT == 4'h5)
    else $error("port count not reduced for disabled ports");
endmodule // uhpsr_top
